// ===== logic/esc_pkg.sv
// constants for the enhanced serial interrupt and flow control block
// assumes a legacy serial core around it supplies events, modem status and fifo state
package esc_pkg;
	// ********************************
	// register offsets
	// ********************************
	localparam logic [2:0] ESC_OFF_CMD = 3'h0;
	localparam logic [2:0] ESC_OFF_ID = 3'h2;
	localparam logic [2:0] ESC_OFF_EN = 3'h3;
	localparam logic [2:0] ESC_OFF_RATE = 3'h4;
	localparam logic [2:0] ESC_OFF_SEL = 3'h5;
	localparam logic [2:0] ESC_OFF_DATA = 3'h6;
	localparam logic [2:0] ESC_OFF_COUNT = 3'h7;
	localparam logic [7:0] ESC_RST_BYTE = 8'h00;
	// ********************************
	// enable register bit positions
	// ********************************
	localparam int ESC_EN_DMA_RX = 7;
	localparam int ESC_EN_DMA_TX = 6;
	localparam int ESC_EN_STATUS = 5;
	localparam int ESC_EN_TC_RX = 4;
	localparam int ESC_EN_TC_TX = 3;
	localparam int ESC_EN_STOP_ERR = 2;
	localparam int ESC_EN_TX_EMPTY = 1;
	localparam int ESC_EN_COUNT = 0;
	// ********************************
	// rate and gating bit positions
	// ********************************
	localparam int ESC_RT_PACING = 7;
	localparam int ESC_RT_HIGH = 6;
	localparam int ESC_RT_SLOW_TX = 5;
	localparam int ESC_RT_SLOW_RX = 4;
	localparam int ESC_RT_RX_DSR = 3;
	localparam int ESC_RT_TX_DCD = 2;
	localparam int ESC_RT_TX_DSR = 1;
	localparam int ESC_RT_TX_CTS = 0;
	// ********************************
	// commands and source codes
	// ********************************
	localparam logic [1:0] ESC_CMD_RESUME = 2'h1;
	localparam logic [1:0] ESC_CMD_STOP = 2'h2;
	localparam logic [1:0] ESC_CMD_CLR_ERR = 2'h3;
	localparam logic [4:0] ESC_ID_TC_RX = 5'h10;
	localparam logic [4:0] ESC_ID_TC_TX = 5'h11;
	localparam logic [4:0] ESC_ID_CMP0 = 5'h18;
	localparam logic [4:0] ESC_ID_CMP1 = 5'h19;
	localparam logic [4:0] ESC_ID_CMP2 = 5'h1a;
	localparam logic [4:0] ESC_ID_COUNT = 5'h12;
	localparam logic [4:0] ESC_ID_TX_EMPTY = 5'h13;
	localparam logic [4:0] ESC_ID_LINE = 5'h03;
	localparam logic [4:0] ESC_ID_RX_DATA = 5'h02;
	localparam logic [4:0] ESC_ID_TIMEOUT = 5'h06;
	localparam logic [4:0] ESC_ID_THR_EMPTY = 5'h01;
	localparam logic [4:0] ESC_ID_MODEM = 5'h00;
	// ********************************
	// timing
	// ********************************
	localparam int ESC_PACE_UNIT = 256;
	localparam int ESC_SLOW_DIV = 16;
	localparam int ESC_TIMEOUT_CHARS = 4;
	localparam logic [1:0] ESC_MIN_DIV_HIGH = 2'h2;
	localparam int ESC_NUM_SLOTS = 3;
	typedef enum logic [1:0] {
		ESC_TX_IDLE = 2'b00,
		ESC_TX_RUN = 2'b01,
		ESC_TX_HALT = 2'b10
	} esc_tx_state_type;
endpackage

// ===== logic/esc_compare_slots.sv
// three match-character and match-function slots with indirect access
// assumes the parent decodes the data register strobes and the slot select
`timescale 1ns/100ps
module esc_compare_slots
	import esc_pkg::*;
#(
	parameter int SLOTS = ESC_NUM_SLOTS
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic [2:0] sel,
	input wire logic wr,
	input wire logic [7:0] wdata,
	input wire logic rx_valid,
	input wire logic [7:0] rx_char,
	output logic [7:0] rdata,
	output logic [SLOTS-1:0] match_irq
);
	if (SLOTS != ESC_NUM_SLOTS) begin : gen_slot_check
		$error("esc_compare_slots: slot count must be three");
	end
	logic [7:0] match_char [SLOTS];
	logic [3:0] match_func [SLOTS];
	// ********************************
	// slot storage
	// ********************************
	// select bits two to one pick the slot, bit zero picks character or function
	genvar g;
	generate
		for (g = 0; g < SLOTS; g++) begin : gen_slot
			always_ff @(posedge core_clk or negedge rstn) begin
				if (!rstn) begin
					match_char[g] <= ESC_RST_BYTE;
					match_func[g] <= 4'h0;
				end else if (wr && sel[2:1] == 2'(g)) begin
					if (sel[0]) match_char[g] <= wdata;
					else match_func[g] <= wdata[3:0];
				end
			end
			// only the interrupt action is served here; start, stop and delete stay with the core
			assign match_irq[g] = rx_valid && match_func[g][0] && rx_char == match_char[g];
		end
	endgenerate
	// read mux; an unused slot address reads zero
	always_comb begin
		rdata = ESC_RST_BYTE;
		if (sel[2:1] < 2'(SLOTS)) begin
			rdata = sel[0] ? match_char[sel[2:1]] : {4'h0, match_func[sel[2:1]]};
		end
	end
endmodule

// ===== logic/esc_ctrl.sv
// enhanced interrupt identification, dma enables and transmit flow control
// assumes a legacy serial core supplies events, modem status and fifo state on core_clk;
// modem lines arrive from pins and are synchronised here
//
// Summary of operation
// - bit zero low when any source pending
// - identity bits seven and six read zero
// - enhanced sources outrank all legacy sources
// - fixed reporting priority order of twelve sources
// - terminal counts cleared by identity read
// - countdown zero and transmitter empty codes
// - line errors cleared by line status read
// - data ready, no trigger level in dma
// - timeout after four idle character times
// - holding empty and modem change codes
// - no transmit dma request before resume
// - status bytes interleaved when storage enabled
// - enables for terminal counts and transmitter empty
// - line error halts transmitter after drain
// - countdown reaching zero raises interrupt
// - pacing spaces bytes, else counts characters
// - high frequency needs divisor two or more
// - slow bits divide rate by sixteen
// - dsr gates receiver, discards partial character
// - line gating follows status after resume
// - stopped transmitter finishes current character only
// - three character and function compare slots
// - select bits two to one choose slot
// - command code one resumes transmission
// - identity read clears like legacy read
// - select bit zero picks character or function
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/100ps
module esc_ctrl
	import esc_pkg::*;
#(
	parameter int DIV_W = 16
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic [2:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	input wire logic fifo_mode,
	input wire logic [DIV_W-1:0] divisor,
	input wire logic tc_rx,
	input wire logic tc_tx,
	input wire logic rx_char_done,
	input wire logic [7:0] rx_char,
	input wire logic rx_line_err,
	input wire logic rx_fifo_pop,
	input wire logic tx_shift_empty,
	input wire logic tx_holding_empty,
	input wire logic legacy_line_irq,
	input wire logic legacy_data_irq,
	input wire logic legacy_timeout_irq,
	input wire logic legacy_thr_irq,
	input wire logic legacy_modem_irq,
	input wire logic dcd_n,
	input wire logic dsr_n,
	input wire logic cts_n,
	output logic tx_load_allow,
	output logic tx_dma_req_allow,
	output logic rx_dma_enable,
	output logic rx_enable,
	output logic rx_discard,
	output logic status_store,
	output logic clear_err_flag,
	output logic high_freq_sel,
	output logic slow_tx,
	output logic slow_rx,
	output logic divisor_ok,
	output logic irq_pending
);
	logic [7:0] en_reg;
	logic [7:0] rate_reg;
	logic [2:0] sel_reg;
	logic [7:0] count_reg;
	logic [2:0] modem_meta;
	logic [2:0] modem_sync;
	logic dsr_prev;
	logic pend_tc_rx;
	logic pend_tc_tx;
	logic [2:0] pend_cmp;
	logic pend_count;
	logic pend_tx_empty;
	logic tx_empty_prev;
	logic [4:0] id_code;
	logic id_none;
	logic [7:0] pace_cnt;
	logic [7:0] pace_left;
	logic resumed;
	logic err_halt;
	logic [7:0] cmp_rdata;
	logic [2:0] cmp_irq;
	logic count_dec;
	logic id_read;
	esc_tx_state_type tx_state;
	esc_tx_state_type next_tx_state;
	// the divisor floor of two must fit in the divisor port
	if (DIV_W < 2) begin : gen_div_check
		$error("esc_ctrl: divisor width too small");
	end
	// command decode shared by every consumer so the codes cannot drift apart
	function automatic logic cmd_hit(input logic w, input logic [2:0] a, input logic [7:0] d, input logic [1:0] code);
		return w && a == ESC_OFF_CMD && d[1:0] == code;
	endfunction
	// ********************************
	// register writes
	// ********************************
	// fifo must already be on before dma bits are set; not checked here
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			en_reg <= ESC_RST_BYTE;
			rate_reg <= ESC_RST_BYTE;
			sel_reg <= 3'h0;
		end else if (wr) begin
			if (addr == ESC_OFF_EN) en_reg <= wdata;
			if (addr == ESC_OFF_RATE) rate_reg <= wdata;
			if (addr == ESC_OFF_SEL) sel_reg <= wdata[2:0]; // upper bits dropped, read as zero
		end
	end
	assign id_read = rd && addr == ESC_OFF_ID;
	// ********************************
	// modem line synchronisers
	// ********************************
	// status bits are the inverted low-active pins: {dcd, dsr, cts}
	// reset to inactive, so the gates see a line come up, never a false drop
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			modem_meta <= 3'h0;
			modem_sync <= 3'h0;
		end else begin
			modem_meta <= {~dcd_n, ~dsr_n, ~cts_n};
			modem_sync <= modem_meta;
		end
	end
	// ********************************
	// receiver gating
	// ********************************
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) dsr_prev <= 1'b0;
		else dsr_prev <= modem_sync[1];
	end
	// discard lasts one clock; the core drops the character it is assembling
	assign rx_enable = !rate_reg[ESC_RT_RX_DSR] || modem_sync[1];
	assign rx_discard = rate_reg[ESC_RT_RX_DSR] && dsr_prev && !modem_sync[1];
	// ********************************
	// rate selects and simple enables
	// ********************************
	// set once at start-up; toggling these mid-character is the user's hazard
	assign high_freq_sel = rate_reg[ESC_RT_HIGH];
	// software must keep the divisor at two or more; flagged, not enforced
	assign divisor_ok = !rate_reg[ESC_RT_HIGH] || divisor >= DIV_W'(ESC_MIN_DIV_HIGH);
	assign slow_tx = rate_reg[ESC_RT_SLOW_TX]; // core divides by ESC_SLOW_DIV
	assign slow_rx = rate_reg[ESC_RT_SLOW_RX];
	assign status_store = en_reg[ESC_EN_STATUS]; // core interleaves status bytes
	assign rx_dma_enable = en_reg[ESC_EN_DMA_RX];
	assign clear_err_flag = cmd_hit(wr, addr, wdata, ESC_CMD_CLR_ERR);
	// ********************************
	// transmitter control
	// ********************************
	// resume is remembered so line gating only acts after the first one
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			resumed <= 1'b0;
			err_halt <= 1'b0;
		end else begin
			if (cmd_hit(wr, addr, wdata, ESC_CMD_RESUME)) resumed <= 1'b1;
			// an error arriving with the resume wins so it is not lost
			if (en_reg[ESC_EN_STOP_ERR] && rx_line_err) err_halt <= 1'b1;
			else if (cmd_hit(wr, addr, wdata, ESC_CMD_RESUME)) err_halt <= 1'b0;
		end
	end
	// stop parks the machine; only a resume leads out of idle or halt
	always_comb begin
		next_tx_state = tx_state;
		unique case (tx_state)
			ESC_TX_IDLE: if (cmd_hit(wr, addr, wdata, ESC_CMD_RESUME)) next_tx_state = ESC_TX_RUN;
			ESC_TX_RUN: if (cmd_hit(wr, addr, wdata, ESC_CMD_STOP)) next_tx_state = ESC_TX_HALT;
			ESC_TX_HALT: if (cmd_hit(wr, addr, wdata, ESC_CMD_RESUME)) next_tx_state = ESC_TX_RUN;
			default: next_tx_state = ESC_TX_IDLE;
		endcase
	end
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) tx_state <= ESC_TX_IDLE;
		else tx_state <= next_tx_state;
	end
	// the shift register always finishes; only the next load is blocked
	always_comb begin
		tx_load_allow = !err_halt && tx_state != ESC_TX_HALT && pace_left == 8'h00;
		if (rate_reg[ESC_RT_TX_DCD] || rate_reg[ESC_RT_TX_DSR] || rate_reg[ESC_RT_TX_CTS]) begin
			tx_load_allow = tx_load_allow && resumed;
		end
		// any enabled gate line that is down stops the next load
		if (rate_reg[ESC_RT_TX_DCD] && !modem_sync[2]) tx_load_allow = 1'b0;
		if (rate_reg[ESC_RT_TX_DSR] && !modem_sync[1]) tx_load_allow = 1'b0;
		if (rate_reg[ESC_RT_TX_CTS] && !modem_sync[0]) tx_load_allow = 1'b0;
	end
	// the dma request obeys every halt, so it never outruns a stopped transmitter
	assign tx_dma_req_allow = en_reg[ESC_EN_DMA_TX] && resumed && tx_load_allow;
	// ********************************
	// countdown and byte pacing
	// ********************************
	// pacing: one decrement every 256 clocks; the value also gaps bytes after each byte leaves the shift register
	assign count_dec = count_reg != 8'h00 && (rate_reg[ESC_RT_PACING]
		? pace_cnt == 8'(ESC_PACE_UNIT - 1) : rx_fifo_pop);
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			count_reg <= ESC_RST_BYTE;
			pace_cnt <= 8'h00;
		end else begin
			pace_cnt <= pace_cnt + 8'h01; // wraps every 256 clocks
			// a write beats a decrement in the same cycle
			if (wr && addr == ESC_OFF_COUNT) count_reg <= wdata;
			else if (count_dec) count_reg <= count_reg - 8'h01; // no wrap below zero
		end
	end
	// gap counted in 256-clock units after each byte leaves the shift register
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			pace_left <= 8'h00;
			tx_empty_prev <= 1'b1;
		end else begin
			tx_empty_prev <= tx_shift_empty;
			// clearing pacing drops any gap at once
			if (!rate_reg[ESC_RT_PACING]) pace_left <= 8'h00;
			else if (!tx_empty_prev && tx_shift_empty) pace_left <= count_reg;
			else if (pace_left != 8'h00 && pace_cnt == 8'(ESC_PACE_UNIT - 1)) pace_left <= pace_left - 8'h01;
		end
	end
	// ********************************
	// compare slots
	// ********************************
	// matches are judged on the received-character pulse only
	esc_compare_slots #(
		.SLOTS(ESC_NUM_SLOTS)
	) u_slots (
		.core_clk(core_clk),
		.rstn(rstn),
		.sel(sel_reg),
		.wr(wr && addr == ESC_OFF_DATA),
		.wdata(wdata),
		.rx_valid(rx_char_done),
		.rx_char(rx_char),
		.rdata(cmp_rdata),
		.match_irq(cmp_irq)
	);
	// ********************************
	// enhanced pending flags
	// ********************************
	// set beats clear; a read clears only the source it reported
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			pend_tc_rx <= 1'b0;
			pend_tc_tx <= 1'b0;
			pend_cmp <= 3'h0;
			pend_count <= 1'b0;
			pend_tx_empty <= 1'b0;
		end else begin
			if (en_reg[ESC_EN_TC_RX] && tc_rx) pend_tc_rx <= 1'b1;
			else if (id_read && id_code == ESC_ID_TC_RX) pend_tc_rx <= 1'b0;
			if (en_reg[ESC_EN_TC_TX] && tc_tx) pend_tc_tx <= 1'b1;
			else if (id_read && id_code == ESC_ID_TC_TX) pend_tc_tx <= 1'b0;
			// a compare slot's own function bit is its enable
			for (int i = 0; i < ESC_NUM_SLOTS; i++) begin
				if (cmp_irq[i]) pend_cmp[i] <= 1'b1;
				else if (id_read && !id_none && id_code == ESC_ID_CMP0 + 5'(i)) pend_cmp[i] <= 1'b0;
			end
			if (en_reg[ESC_EN_COUNT] && count_dec && count_reg == 8'h01) pend_count <= 1'b1;
			else if (id_read && id_code == ESC_ID_COUNT) pend_count <= 1'b0;
			if (en_reg[ESC_EN_TX_EMPTY] && tx_shift_empty && tx_holding_empty && !tx_empty_prev)
				pend_tx_empty <= 1'b1;
			else if (id_read && id_code == ESC_ID_TX_EMPTY) pend_tx_empty <= 1'b0;
		end
	end
	// ********************************
	// priority encoder
	// ********************************
	// legacy flags are owned by the core, which clears them on its own register reads
	// enhanced flags come first, so any enabled one outranks all legacy ones
	always_comb begin
		id_none = 1'b0;
		id_code = ESC_ID_MODEM;
		if (pend_tc_rx) id_code = ESC_ID_TC_RX;
		else if (pend_tc_tx) id_code = ESC_ID_TC_TX;
		else if (pend_cmp[0]) id_code = ESC_ID_CMP0;
		else if (pend_cmp[1]) id_code = ESC_ID_CMP1;
		else if (pend_cmp[2]) id_code = ESC_ID_CMP2;
		else if (pend_count) id_code = ESC_ID_COUNT;
		else if (pend_tx_empty) id_code = ESC_ID_TX_EMPTY;
		else if (legacy_line_irq) id_code = ESC_ID_LINE;
		else if (legacy_data_irq) // the core drops trigger-level requests in dma mode
			id_code = ESC_ID_RX_DATA;
		else if (legacy_timeout_irq) id_code = ESC_ID_TIMEOUT;
		else if (legacy_thr_irq) id_code = ESC_ID_THR_EMPTY;
		else if (legacy_modem_irq) id_code = ESC_ID_MODEM;
		else id_none = 1'b1;
	end
	assign irq_pending = !id_none;
	// ********************************
	// read port
	// ********************************
	// idle cycles read zero so a stale byte never passes for an answer
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) rdata <= ESC_RST_BYTE;
		else if (rd) begin
			unique case (addr)
				ESC_OFF_ID: rdata <= {2'b00, id_code, id_none};
				ESC_OFF_EN: rdata <= en_reg;
				ESC_OFF_RATE: rdata <= rate_reg;
				ESC_OFF_SEL: rdata <= {5'h00, sel_reg};
				ESC_OFF_DATA: rdata <= cmp_rdata;
				ESC_OFF_COUNT: rdata <= count_reg;
				default: rdata <= ESC_RST_BYTE;
			endcase
		end else rdata <= ESC_RST_BYTE;
	end
endmodule

// ===== verif/esc_ctrl_props.sv
// checker for the port behaviour of esc_ctrl
// assumes it is bound to each esc_ctrl instance and sees its ports only
`timescale 1ns/100ps
module esc_ctrl_props
	import esc_pkg::*;
#(
	parameter int DIV_W = 16
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic [2:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata,
	input wire logic [DIV_W-1:0] divisor,
	input wire logic tc_rx,
	input wire logic rx_line_err,
	input wire logic tx_shift_empty,
	input wire logic tx_holding_empty,
	input wire logic dsr_n,
	input wire logic cts_n,
	input wire logic tx_load_allow,
	input wire logic tx_dma_req_allow,
	input wire logic rx_dma_enable,
	input wire logic rx_enable,
	input wire logic rx_discard,
	input wire logic status_store,
	input wire logic clear_err_flag,
	input wire logic high_freq_sel,
	input wire logic slow_tx,
	input wire logic slow_rx,
	input wire logic divisor_ok,
	input wire logic irq_pending
);
	// ****************
	// shadows of software writes
	// ****************
	logic [7:0] en_sh;
	logic [7:0] rate_sh;
	logic resumed;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rstn);
	// enable and rate bytes as last written
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			en_sh <= 8'h00;
			rate_sh <= 8'h00;
		end else if (wr && addr == ESC_OFF_EN) begin
			en_sh <= wdata;
		end else if (wr && addr == ESC_OFF_RATE) begin
			rate_sh <= wdata;
		end
	end
	// first resume seen; later stops are not tracked, so only the idle side is checked
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			resumed <= 1'b0;
		end else if (wr && addr == ESC_OFF_CMD && wdata[1:0] == ESC_CMD_RESUME) begin
			resumed <= 1'b1;
		end
	end
	// ****************
	// assertions
	// ****************
	id_reserved_a: assert property (rd && addr == ESC_OFF_ID |=> rdata[7:6] == 2'h0)
		else $error("identity top bits not zero");
	id_pending_a: assert property (rd && addr == ESC_OFF_ID |=> rdata[0] == !$past(irq_pending))
		else $error("identity pending bit wrong");
	dma_hold_a: assert property (!resumed |-> !tx_dma_req_allow)
		else $error("transmit dma request before resume");
	mirror_bits_a: assert property (status_store == en_sh[5] && rx_dma_enable == en_sh[7])
		else $error("enable outputs differ from register");
	rate_bits_a: assert property (slow_tx == rate_sh[5] && slow_rx == rate_sh[4] && high_freq_sel == rate_sh[6])
		else $error("rate outputs differ from register");
	divisor_check_a: assert property (divisor_ok == (!high_freq_sel || divisor >= 2))
		else $error("divisor check wrong");
	cts_gate_a: assert property ((rate_sh[0] && cts_n) [*4] |-> !tx_load_allow)
		else $error("transmitter runs with clear to send off");
	dsr_gate_a: assert property ((rate_sh[3] && dsr_n) [*4] |-> !rx_enable)
		else $error("receiver runs with data set ready off");
	discard_pulse_a: assert property (rx_discard |-> rate_sh[3] ##1 !rx_discard)
		else $error("discard pulse wrong");
	line_halt_a: assert property ((rx_line_err && en_sh[2]) ##1 (!wr) [*2] |-> !tx_load_allow)
		else $error("transmitter not halted on line error");
	tc_irq_a: assert property (tc_rx && en_sh[4] |-> ##[0:2] irq_pending)
		else $error("terminal count not pending");
	tx_empty_irq_a: assert property (en_sh[1] && $rose(tx_shift_empty && tx_holding_empty) |-> ##[0:2] irq_pending)
		else $error("transmitter empty not pending");
	clear_cmd_a: assert property (clear_err_flag ==
		(wr && addr == ESC_OFF_CMD && wdata[1:0] == ESC_CMD_CLR_ERR))
		else $error("clear error pulse wrong");
endmodule

bind esc_ctrl esc_ctrl_props #(.DIV_W(DIV_W)) esc_ctrl_props_i (.core_clk(core_clk), .rstn(rstn), .addr(addr),
	.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .divisor(divisor), .tc_rx(tc_rx), .rx_line_err(rx_line_err),
	.tx_shift_empty(tx_shift_empty), .tx_holding_empty(tx_holding_empty), .dsr_n(dsr_n), .cts_n(cts_n),
	.tx_load_allow(tx_load_allow), .tx_dma_req_allow(tx_dma_req_allow), .rx_dma_enable(rx_dma_enable),
	.rx_enable(rx_enable), .rx_discard(rx_discard), .status_store(status_store), .high_freq_sel(high_freq_sel),
	.slow_tx(slow_tx), .slow_rx(slow_rx), .divisor_ok(divisor_ok), .irq_pending(irq_pending),
	.clear_err_flag(clear_err_flag));

// ===== verif/esc_modem_model.sv
// modem side: drives the three active-low status lines
// assumes the bench sets the wanted line states; lines follow lag plus one clocks later
`timescale 1ns/100ps
module esc_modem_model (
	input wire logic core_clk,
	input wire logic [2:0] want,
	input wire logic [3:0] lag,
	output logic [2:0] line_n
);
	logic [2:0] held = 3'h7;
	logic [3:0] wait_cnt = 4'h0;
	assign line_n = held;
	// a slow modem answers late; lag zero answers on the next clock
	always @(posedge core_clk) begin
		if (held != ~want && wait_cnt < lag) begin
			wait_cnt <= wait_cnt + 4'h1;
		end else begin
			wait_cnt <= 4'h0;
			held <= ~want;
		end
	end
endmodule

// ===== verif/tb_top.sv
// self-checking bench for esc_ctrl with a modem model
// assumes the register offsets and codes of esc_pkg
`timescale 1ns/100ps
module tb_top
	import esc_pkg::*;
;
	typedef struct {
		logic [2:0] a;
		logic [7:0] w;
		logic [7:0] e;
	} esc_row_type;
	logic core_clk, rstn, wr, rd, fifo_mode, tc_rx, tc_tx, rx_char_done, rx_line_err, rx_fifo_pop;
	logic tx_shift_empty, tx_holding_empty, tx_load_allow, tx_dma_req_allow, rx_dma_enable, rx_enable;
	logic rx_discard, status_store, high_freq_sel, slow_tx, slow_rx, divisor_ok, irq_pending;
	logic [2:0] addr, want, line_n;
	logic [7:0] wdata, rdata, rx_char, got;
	logic [15:0] divisor;
	logic [4:0] leg;
	logic [3:0] lag;
	int err_total, cmp_count, disc_seen;
	esc_row_type rows [13];
	logic [7:0] pri_exp [7];
	logic [7:0] leg_exp [6];
	esc_modem_model esc_modem_model_i (.core_clk(core_clk), .want(want), .lag(lag), .line_n(line_n));
	esc_ctrl esc_ctrl_i (.core_clk(core_clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .fifo_mode(fifo_mode), .divisor(divisor), .tc_rx(tc_rx), .tc_tx(tc_tx),
		.rx_char_done(rx_char_done), .rx_char(rx_char), .rx_line_err(rx_line_err), .rx_fifo_pop(rx_fifo_pop),
		.tx_shift_empty(tx_shift_empty), .tx_holding_empty(tx_holding_empty), .legacy_line_irq(leg[4]),
		.legacy_data_irq(leg[3]), .legacy_timeout_irq(leg[2]), .legacy_thr_irq(leg[1]),
		.legacy_modem_irq(leg[0]), .dcd_n(line_n[2]), .dsr_n(line_n[1]), .cts_n(line_n[0]),
		.tx_load_allow(tx_load_allow), .tx_dma_req_allow(tx_dma_req_allow), .rx_dma_enable(rx_dma_enable),
		.rx_enable(rx_enable), .rx_discard(rx_discard), .status_store(status_store), .clear_err_flag(),
		.high_freq_sel(high_freq_sel), .slow_tx(slow_tx), .slow_rx(slow_rx), .divisor_ok(divisor_ok),
		.irq_pending(irq_pending));
	// ****************
	// bus tasks and compare
	// ****************
	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		@(posedge core_clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge core_clk);
		wr <= 1'b0;
		#1; // callers look at outputs only once the write has landed
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [2:0] a);
		@(posedge core_clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge core_clk);
		rd <= 1'b0;
		#1 got = rdata;
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("BAD t=%0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic rx_byte(input logic [7:0] c);
		@(posedge core_clk);
		rx_char_done <= 1'b1;
		rx_fifo_pop <= 1'b1;
		rx_char <= c;
		@(posedge core_clk);
		rx_char_done <= 1'b0;
		rx_fifo_pop <= 1'b0;
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// 200 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	// count discard pulses from the receiver gate
	always @(posedge core_clk) begin
		if (rx_discard === 1'b1) disc_seen++;
	end
	// a hang is cut well past the expected two hundred or so clocks
	initial begin
		#100000;
		err_total++;
		$display("BAD t=%0t watchdog expired", $time);
		report_and_stop();
	end
	// ****************
	// main sequence
	// ****************
	initial begin
		{rstn, wr, rd, fifo_mode, tc_rx, tc_tx, rx_char_done, rx_line_err, rx_fifo_pop} = 9'h0;
		{tx_shift_empty, tx_holding_empty, addr, wdata, rx_char, leg, lag} = 30'h0;
		{want, divisor} = {3'h7, 16'h0001};
		{err_total, cmp_count, disc_seen} = {32'h0, 32'h0, 32'h0};
		rows = '{'{3'h3, 8'ha5, 8'ha5}, '{3'h3, 8'h5a, 8'h5a}, '{3'h4, 8'hc3, 8'hc3}, '{3'h4, 8'h3c, 8'h3c},
			'{3'h5, 8'hff, 8'h07}, '{3'h5, 8'h03, 8'h03}, '{3'h6, 8'h77, 8'h77}, '{3'h5, 8'h02, 8'h02},
			'{3'h6, 8'h0a, 8'h0a}, '{3'h1, 8'hff, 8'h00}, '{3'h2, 8'hff, 8'h01}, '{3'h0, 8'h00, 8'h00},
			'{3'h7, 8'h05, 8'h05}};
		pri_exp = '{8'h20, 8'h22, 8'h30, 8'h34, 8'h24, 8'h26, 8'h06};
		leg_exp = '{8'h06, 8'h04, 8'h0c, 8'h02, 8'h00, 8'h01};
		repeat (20) @(posedge core_clk);
		rstn <= 1'b1;
		foreach (rows[i]) begin
			wr_reg(rows[i].a, rows[i].w);
			rd_reg(rows[i].a);
			chk(got, rows[i].e);
		end
		$display("register rows done");
		// mid-run reset clears the software registers
		@(posedge core_clk) rstn <= 1'b0;
		repeat (2) @(posedge core_clk);
		rstn <= 1'b1;
		for (int k = 3; k < 6; k++) begin
			rd_reg(k[2:0]);
			chk(got, ESC_RST_BYTE);
		end
		rd_reg(ESC_OFF_ID);
		chk(got, 8'h01);
		$display("reset test done");
		// every enhanced source but compare slot one, plus two legacy ones, pending at once
		wr_reg(ESC_OFF_EN, 8'h1b);
		wr_reg(ESC_OFF_SEL, 8'h01);
		wr_reg(ESC_OFF_DATA, 8'h41);
		wr_reg(ESC_OFF_SEL, 8'h00);
		wr_reg(ESC_OFF_DATA, 8'h01);
		wr_reg(ESC_OFF_SEL, 8'h05);
		wr_reg(ESC_OFF_DATA, 8'h43);
		wr_reg(ESC_OFF_SEL, 8'h04);
		wr_reg(ESC_OFF_DATA, 8'h01);
		wr_reg(ESC_OFF_COUNT, 8'h02);
		@(posedge core_clk) {tc_rx, tc_tx, tx_shift_empty, tx_holding_empty, leg} <= 9'h1f1;
		@(posedge core_clk) {tc_rx, tc_tx} <= 2'h0;
		rx_byte(8'h41);
		rx_byte(8'h43);
		foreach (pri_exp[k]) begin
			rd_reg(ESC_OFF_ID);
			chk(got, pri_exp[k]);
		end
		$display("priority test done");
		// legacy sources released from the top down
		@(posedge core_clk) leg <= 5'h1f;
		foreach (leg_exp[k]) begin
			rd_reg(ESC_OFF_ID);
			chk(got, leg_exp[k]);
			if (k < 5) @(posedge core_clk) leg[4-k] <= 1'b0;
		end
		$display("legacy test done");
		// fifo mode goes first, then dma transmit with stop on error
		@(posedge core_clk) fifo_mode <= 1'b1;
		wr_reg(ESC_OFF_EN, 8'h44);
		chk({7'h0, tx_dma_req_allow}, 8'h00);
		wr_reg(ESC_OFF_CMD, 8'h01);
		chk({6'h0, tx_dma_req_allow, tx_load_allow}, 8'h03);
		@(posedge core_clk) rx_line_err <= 1'b1;
		@(posedge core_clk) rx_line_err <= 1'b0;
		repeat (3) @(posedge core_clk);
		chk({7'h0, tx_load_allow}, 8'h00);
		wr_reg(ESC_OFF_CMD, 8'h01);
		chk({7'h0, tx_load_allow}, 8'h01);
		wr_reg(ESC_OFF_CMD, 8'h02);
		chk({7'h0, tx_load_allow}, 8'h00);
		wr_reg(ESC_OFF_CMD, 8'h03);
		wr_reg(ESC_OFF_CMD, 8'h01);
		chk({7'h0, tx_load_allow}, 8'h01);
		// slow modem drops clear to send, then raises it
		wr_reg(ESC_OFF_RATE, 8'h01);
		{want, lag} <= {3'h6, 4'h3};
		repeat (10) @(posedge core_clk);
		chk({7'h0, tx_load_allow}, 8'h00);
		want <= 3'h7;
		repeat (10) @(posedge core_clk);
		chk({7'h0, tx_load_allow}, 8'h01);
		// prompt modem drops data set ready under receiver gating
		wr_reg(ESC_OFF_RATE, 8'h08);
		{want, lag} <= {3'h5, 4'h0};
		repeat (10) @(posedge core_clk);
		chk({7'h0, rx_enable}, 8'h00);
		chk(disc_seen[7:0], 8'h01);
		want <= 3'h7;
		repeat (10) @(posedge core_clk);
		chk({7'h0, rx_enable}, 8'h01);
		$display("flow control test done");
		report_and_stop();
	end
endmodule
